/* File: logic/dlc_pkg.sv */
`default_nettype none
package dlc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ           = 20_000_000;
  localparam int unsigned HOLD_SECONDS     = 60;
  localparam int unsigned SLOW_HALF_MS     = 500;
  localparam int unsigned FAST_HALF_MS     = 100;
  localparam int unsigned PAUSE_MS         = 2000;
  localparam int unsigned ASC_SECONDS      = 300;
  localparam int unsigned HOLD_CYCLES      = HOLD_SECONDS * CLK_HZ;
  localparam int unsigned SLOW_HALF_CYCLES = SLOW_HALF_MS * (CLK_HZ / 1000);
  localparam int unsigned FAST_HALF_CYCLES = FAST_HALF_MS * (CLK_HZ / 1000);
  localparam int unsigned PAUSE_CYCLES     = PAUSE_MS * (CLK_HZ / 1000);
  // Five minutes of clock cycles does not fit in 32 bits.
  localparam longint unsigned ASC_CYCLES   = 64'(ASC_SECONDS) * 64'(CLK_HZ);

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam int unsigned NUM_FAULTS = 8;
  localparam int unsigned IDX_W      = 3;
  localparam int unsigned CNT_W      = 4;

  // One LED of a pair: steady level, or a count of fast flashes then pause.
  typedef struct packed {
    logic             steady;
    logic [CNT_W-1:0] flashes;
  } dlc_led_code_type;

  typedef struct packed {
    dlc_led_code_type green;
    dlc_led_code_type red;
  } dlc_pair_code_type;

  typedef enum logic [1:0] {
    DLC_BLINK_OFF,
    DLC_BLINK_SLOW_SAME,
    DLC_BLINK_SLOW_ALT,
    DLC_BLINK_CODE
  } dlc_blink_type;

endpackage : dlc_pkg
`default_nettype wire

/* File: logic/dlc_flash_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module dlc_flash_gen #(
  parameter int unsigned FAST_HALF = dlc_pkg::FAST_HALF_CYCLES,
  parameter int unsigned PAUSE     = dlc_pkg::PAUSE_CYCLES
) (
  input  wire logic                         clk,
  input  wire logic                         rstn,
  input  wire dlc_pkg::dlc_led_code_type    code,
  output logic                              led
);
  // ----------------------------------------------------------------
  // Fast flash count then pause
  // ----------------------------------------------------------------
  logic [31:0]              tmr_q;
  logic [dlc_pkg::CNT_W:0]  ph_q;
  logic                     end_w;
  logic                     last_w;

  assign end_w  = (tmr_q == 32'h0);
  // A code that shrinks mid-round ends the round when the current phase expires instead of wrapping.
  assign last_w = (ph_q >= {code.flashes, 1'b0});

  // Phases 0..2n-1 alternate off/on, odd ones lit; phase 2n is the pause. [R11]
  always_ff @(posedge clk) begin
    if (!rstn || code.flashes == '0) begin
      tmr_q <= 32'(FAST_HALF - 1);
      ph_q  <= '0;
      led   <= 1'b0;
    end else if (end_w) begin
      ph_q  <= last_w ? '0 : ph_q + 1'b1;
      tmr_q <= (ph_q == {code.flashes, 1'b0} - 1'b1) ? 32'(PAUSE - 1) : 32'(FAST_HALF - 1);
      led   <= !last_w && !ph_q[0];
    end else begin
      tmr_q <= tmr_q - 32'h1;
    end
  end
endmodule : dlc_flash_gen
`default_nettype wire

/* File: logic/dlc_display.sv */
`timescale 1ns/1ps
`default_nettype none
// How it works
// [R01] Active fault code overrides status pattern.
// [R02] Only newest active fault is shown.
// [R03] No fault: show operating status pattern.
// [R04] Stored code shown 60 s after power-up.
// [R05] Fault code clears when condition returns normal.
// [R06] Normal or standby: slow in-phase flash.
// [R07] Anti-short-cycle delay: slow alternating flash.
// [R08] Service jumper cuts anti-short-cycle delay short.
// [R09] Internal failure: both status LEDs steady on.
// [R10] Compressor LEDs only indicate, never control.
// [R11] Flash timing from parameterised cycle counts.
module dlc_display #(
  parameter int unsigned N          = dlc_pkg::NUM_FAULTS,
  parameter int unsigned HOLD       = dlc_pkg::HOLD_CYCLES,
  parameter longint unsigned ASC    = dlc_pkg::ASC_CYCLES,
  parameter int unsigned SLOW_HALF  = dlc_pkg::SLOW_HALF_CYCLES,
  parameter int unsigned FAST_HALF  = dlc_pkg::FAST_HALF_CYCLES,
  parameter int unsigned PAUSE      = dlc_pkg::PAUSE_CYCLES
) (
  input  wire logic                          clk,
  input  wire logic                          rstn,
  input  wire logic [N-1:0]                  fault_active,
  input  wire dlc_pkg::dlc_pair_code_type    fault_code [N],
  input  wire logic                          stored_valid,
  input  wire dlc_pkg::dlc_pair_code_type    stored_code,
  input  wire dlc_pkg::dlc_pair_code_type    status_code,
  input  wire logic                          status_valid,
  input  wire logic                          asc_start,
  input  wire logic                          service_override_jumper,
  input  wire logic                          internal_failure,
  input  wire dlc_pkg::dlc_pair_code_type    comp_code,
  output logic                               green_status_led,
  output logic                               red_status_led,
  output logic                               yellow_compressor_led,
  output logic                               red_compressor_led
);
  // ----------------------------------------------------------------
  // Newest active fault tracking
  // ----------------------------------------------------------------
  // Each fault keeps an age; a rising fault gets age zero, the rest age.
  // Saturating ages keep order until the newer of two faults has seen 15 later rises.
  logic [N-1:0]              prev_q;
  logic [N-1:0]              rise_w;
  logic [dlc_pkg::IDX_W:0]   age_q [N];
  logic                      any_fault_w;
  logic [dlc_pkg::IDX_W-1:0] newest_w;

  assign rise_w      = fault_active & ~prev_q;
  assign any_fault_w = |fault_active;

  generate
    for (genvar i = 0; i < N; i++) begin : g_age
      always_ff @(posedge clk) begin
        if (!rstn) begin
          age_q[i] <= '1;
        end else if (rise_w[i]) begin
          age_q[i] <= '0;
        end else if (|rise_w && age_q[i] != '1) begin
          age_q[i] <= age_q[i] + 1'b1;
        end
      end
    end
  endgenerate

  function automatic logic [dlc_pkg::IDX_W-1:0] pick_newest(
    input logic [N-1:0] act,
    input logic [dlc_pkg::IDX_W:0] ages [N]);
    logic [dlc_pkg::IDX_W-1:0] best;
    logic [dlc_pkg::IDX_W:0]   best_age;
    best     = '0;
    best_age = '1;
    for (int k = 0; k < N; k++) begin
      if (act[k] && ages[k] <= best_age) begin
        best     = dlc_pkg::IDX_W'(k);
        best_age = ages[k];
      end
    end
    return best;
  endfunction : pick_newest

  assign newest_w = pick_newest(fault_active, age_q); // [R02]

  // ----------------------------------------------------------------
  // Power-up hold and anti-short-cycle timers
  // ----------------------------------------------------------------
  logic [31:0] hold_q;
  logic [63:0] asc_q;
  logic        hold_on_w;
  logic        asc_on_w;

  assign hold_on_w = stored_valid && hold_q != 32'h0;
  assign asc_on_w  = asc_q != 64'h0;

  always_ff @(posedge clk) begin
    prev_q <= rstn ? fault_active : '0;
    if (!rstn) begin
      hold_q <= 32'(HOLD);
      asc_q  <= 64'(ASC);
    end else begin
      hold_q <= hold_on_w ? hold_q - 32'h1 : 32'h0;          // [R04]
      if (service_override_jumper) begin
        asc_q <= 64'h0;                                        // [R08]
      end else if (asc_start) begin
        asc_q <= 64'(ASC);                                     // [R07]
      end else if (asc_on_w) begin
        asc_q <= asc_q - 64'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pattern selection
  // ----------------------------------------------------------------
  dlc_pkg::dlc_blink_type    mode_w;
  dlc_pkg::dlc_pair_code_type sel_w;

  // Live faults come first, so a stored code cannot mask a new one.
  assign sel_w  = any_fault_w ? fault_code[newest_w]          // [R01] [R05]
                : hold_on_w   ? stored_code                    // [R04]
                :               status_code;                   // [R03]
  assign mode_w = (internal_failure)             ? dlc_pkg::DLC_BLINK_CODE
                : (any_fault_w || hold_on_w)     ? dlc_pkg::DLC_BLINK_CODE
                : asc_on_w                       ? dlc_pkg::DLC_BLINK_SLOW_ALT
                : status_valid                   ? dlc_pkg::DLC_BLINK_CODE
                :                                  dlc_pkg::DLC_BLINK_SLOW_SAME;

  logic [31:0] slow_q;
  logic        slow_ph_q;
  logic        g_code_w;
  logic        r_code_w;
  logic        g_d;
  logic        r_d;

  always_ff @(posedge clk) begin
    if (!rstn || slow_q == 32'h0) begin
      slow_q    <= 32'(SLOW_HALF - 1);                         // [R11]
      slow_ph_q <= rstn ? ~slow_ph_q : 1'b0;
    end else begin
      slow_q    <= slow_q - 32'h1;
    end
  end

  dlc_flash_gen #(.FAST_HALF(FAST_HALF), .PAUSE(PAUSE)) u_g (
    .clk  (clk),
    .rstn (rstn),
    .code (sel_w.green),
    .led  (g_code_w)
  );
  dlc_flash_gen #(.FAST_HALF(FAST_HALF), .PAUSE(PAUSE)) u_r (
    .clk  (clk),
    .rstn (rstn),
    .code (sel_w.red),
    .led  (r_code_w)
  );

  always_comb begin
    g_d = 1'b0;
    r_d = 1'b0;
    case (mode_w)
      dlc_pkg::DLC_BLINK_SLOW_SAME: begin
        g_d = slow_ph_q;                                       // [R06]
        r_d = slow_ph_q;
      end
      dlc_pkg::DLC_BLINK_SLOW_ALT: begin
        g_d = slow_ph_q;                                       // [R07]
        r_d = ~slow_ph_q;
      end
      dlc_pkg::DLC_BLINK_CODE: begin
        g_d = sel_w.green.steady | g_code_w;
        r_d = sel_w.red.steady | r_code_w;
      end
      default: begin
        g_d = 1'b0;
        r_d = 1'b0;
      end
    endcase
    if (internal_failure) begin
      g_d = 1'b1;                                              // [R09]
      r_d = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Compressor pair: display only, no outputs besides LEDs
  // ----------------------------------------------------------------
  logic yc_w;
  logic rc_w;

  dlc_flash_gen #(.FAST_HALF(FAST_HALF), .PAUSE(PAUSE)) u_yc (
    .clk  (clk),
    .rstn (rstn),
    .code (comp_code.green),
    .led  (yc_w)
  );
  dlc_flash_gen #(.FAST_HALF(FAST_HALF), .PAUSE(PAUSE)) u_rc (
    .clk  (clk),
    .rstn (rstn),
    .code (comp_code.red),
    .led  (rc_w)
  );

  always_ff @(posedge clk) begin
    if (!rstn) begin
      green_status_led      <= 1'b0;
      red_status_led        <= 1'b0;
      yellow_compressor_led <= 1'b0;
      red_compressor_led    <= 1'b0;
    end else begin
      green_status_led      <= g_d;
      red_status_led        <= r_d;
      yellow_compressor_led <= comp_code.green.steady | yc_w;  // [R10]
      red_compressor_led    <= comp_code.red.steady | rc_w;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_fail_steady: assert property (@(posedge clk) disable iff (!rstn) // [R09]
    internal_failure |=> green_status_led && red_status_led)
    else $error("Internal failure did not light both LEDs.");
  a_jumper_cuts: assert property (@(posedge clk) disable iff (!rstn) // [R08]
    service_override_jumper |=> asc_q == 64'h0)
    else $error("Jumper did not end the delay.");
  a_alt_flash: assert property (@(posedge clk) disable iff (!rstn) // [R07]
    (mode_w == dlc_pkg::DLC_BLINK_SLOW_ALT && !internal_failure)
      |=> green_status_led != red_status_led)
    else $error("Delay pattern not alternating.");
  a_same_flash: assert property (@(posedge clk) disable iff (!rstn) // [R06]
    (mode_w == dlc_pkg::DLC_BLINK_SLOW_SAME && !internal_failure)
      |=> green_status_led == red_status_led)
    else $error("Normal pattern not in phase.");
  a_fault_wins: assert property (@(posedge clk) disable iff (!rstn) // [R01]
    (any_fault_w && !internal_failure && fault_code[newest_w].red == '0)
      |=> !red_status_led)
    else $error("Fault code not shown.");
  a_newest_shown: assert property (@(posedge clk) disable iff (!rstn) // [R02]
    (rise_w[0] && $stable(fault_active[N-1:1]) && fault_active[0])
      |=> (!fault_active[0] || |rise_w || newest_w == '0))
    else $error("Newest fault not selected.");
  a_hold_ends: assert property (@(posedge clk) disable iff (!rstn) // [R04]
    (hold_q == 32'h1 && stored_valid) |=> !hold_on_w)
    else $error("Stored code held too long.");
  a_status_shown: assert property (@(posedge clk) disable iff (!rstn) // [R03]
    (!any_fault_w && !hold_on_w && !asc_on_w && status_valid && !internal_failure
      && status_code.red.steady) |=> red_status_led)
    else $error("Status pattern not selected.");
  a_auto_clear: assert property (@(posedge clk) disable iff (!rstn) // [R05]
    ($fell(any_fault_w) && !hold_on_w && !asc_on_w && status_valid && !internal_failure
      && status_code.red.steady) |=> red_status_led)
    else $error("Cleared fault still shown.");
  c_flash: cover property (@(posedge clk) disable iff (!rstn) $rose(yellow_compressor_led));
  c_fault: cover property (@(posedge clk) disable iff (!rstn) any_fault_w);
  c_asc: cover property (@(posedge clk) disable iff (!rstn) asc_on_w ##1 !asc_on_w);
  c_two: cover property (@(posedge clk) disable iff (!rstn) $countones(fault_active) > 1);
endmodule : dlc_display
`default_nettype wire

/* File: tb/dlc_observer.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Watches the status pair from outside the unit.
// ------------------------------------------------------------
module dlc_observer (
  input  wire logic clk,
  input  wire logic green,
  input  wire logic red,
  output int        flips
);
  int   cnt_q = 0;
  logic green_q;
  assign flips = cnt_q;
  // Counting flips of green alone tells a blinking pair from one stuck at a level.
  always @(posedge clk) begin
    if (green !== green_q) cnt_q <= cnt_q + 1;
    green_q <= green;
  end
endmodule : dlc_observer
`default_nettype wire

/* File: tb/diag_led_code_display_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module diag_led_code_display_bench;
  localparam int unsigned N = dlc_pkg::NUM_FAULTS;
  localparam int          FH = 2;
  localparam int          PS = 5;
  logic                       clk = 1'b0;
  logic                       rstn = 1'b0;
  logic [N-1:0]               fault_active = '0;
  dlc_pkg::dlc_pair_code_type fault_code [N];
  logic                       stored_valid = 1'b0;
  logic                       status_valid = 1'b0;
  logic                       asc_start = 1'b0;
  logic                       jumper = 1'b0;
  logic                       int_fail = 1'b0;
  logic                       hold_on = 1'b0;
  dlc_pkg::dlc_pair_code_type stored_code = '0;
  dlc_pkg::dlc_pair_code_type status_code = '0;
  dlc_pkg::dlc_pair_code_type comp_code = '0;
  logic                       g, r, y, rc;
  int                         fails = 0;
  int                         n_checks = 0;
  int                         flips, f0, idx;
  int                         act[$];

  always #25 clk = ~clk;

  // Short counts keep the run brief; every expectation below is derived from them.
  dlc_display #(.N(N), .HOLD(50), .ASC(80), .SLOW_HALF(6), .FAST_HALF(FH), .PAUSE(PS)) u_dut (
    .clk(clk), .rstn(rstn), .fault_active(fault_active), .fault_code(fault_code),
    .stored_valid(stored_valid), .stored_code(stored_code), .status_code(status_code),
    .status_valid(status_valid), .asc_start(asc_start), .service_override_jumper(jumper),
    .internal_failure(int_fail), .comp_code(comp_code), .green_status_led(g),
    .red_status_led(r), .yellow_compressor_led(y), .red_compressor_led(rc));

  dlc_observer u_obs (.clk(clk), .green(g), .red(r), .flips(flips));

  // ------------------------------------------------------------
  // Reference model and checks.
  // ------------------------------------------------------------
  function automatic logic [1:0] exp_pair();
    if (int_fail) return 2'h3;
    if (act.size() > 0) return {fault_code[act[$]].green.steady, fault_code[act[$]].red.steady};
    if (hold_on) return {stored_code.green.steady, stored_code.red.steady};
    return {status_code.green.steady, status_code.red.steady};
  endfunction : exp_pair

  task automatic cmp(input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // Mode 0 compares with the model, 1 wants the pair opposite, 2 wants it together.
  task automatic step(input int n, input int mode);
    repeat (n) begin
      @(negedge clk);
      if (mode == 0) cmp({g, r}, exp_pair());
      else cmp({1'b0, g ^ r}, {1'b0, mode == 1});
    end
    @(posedge clk);
  endtask : step

  // Counts LED rises over a window; a round of n flashes lasts 2n*FH+PS cycles.
  task automatic flash_count(input int n, input int ylo, input int yhi,
                             input int rlo, input int rhi);
    int   ny = 0;
    int   nr = 0;
    logic py;
    logic pr;
    py = y;
    pr = rc;
    repeat (n) begin
      @(negedge clk);
      if (y && !py) ny++;
      if (rc && !pr) nr++;
      py = y;
      pr = rc;
    end
    @(posedge clk);
    cmp({1'b0, ny >= ylo && ny <= yhi}, 2'h1);
    cmp({1'b0, nr >= rlo && nr <= rhi}, 2'h1);
  endtask : flash_count

  task automatic fault(input int i, input logic on);
    int q[$];
    @(posedge clk);
    fault_active[i] <= on;
    q = act.find_first_index(x) with (x == i);
    if (q.size() > 0) act.delete(q[0]);
    if (on) act.push_back(i);
  endtask : fault

  task automatic blink(input int n, input int mode, input int lo, input int hi);
    f0 = flips;
    step(n, mode);
    cmp({1'b0, (flips - f0) >= lo && (flips - f0) <= hi}, 2'h1);
  endtask : blink

  task automatic close_out();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out

  // A hung sequence is cut off here and reported as a failure.
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    close_out();
  end

  // ------------------------------------------------------------
  // Main sequence.
  // ------------------------------------------------------------
  initial begin
    void'($urandom(85));
    for (int i = 0; i < N; i++) fault_code[i] = {i[0], 4'h0, i[1], 4'h0};
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    blink(60, 1, 9, 11);
    $display("end of power-up delay test");
    repeat (40) @(posedge clk);
    blink(30, 2, 4, 6);
    $display("end of idle test");
    status_code <= 10'h010;
    status_valid <= 1'b1;
    repeat (3) @(posedge clk);
    step(10, 0);
    repeat (16) begin
      idx = $urandom_range(N - 1);
      fault(idx, !fault_active[idx]);
      repeat (3) @(posedge clk);
      step(4, 0);
    end
    while (act.size() > 0) begin
      fault(act[0], 1'b0);
      repeat (3) @(posedge clk);
      step(3, 0);
    end
    $display("end of fault priority test");
    fault(3, 1'b1);
    int_fail <= 1'b1;
    repeat (3) @(posedge clk);
    step(8, 0);
    int_fail <= 1'b0;
    fault(3, 1'b0);
    for (int c = 0; c < 4; c++) begin
      comp_code <= {c[1], 4'h0, c[0], 4'h0};
      repeat (3) @(posedge clk);
      @(negedge clk);
      cmp({y, rc}, c[1:0]);
      step(2, 0);
    end
    comp_code <= {1'b0, 4'h3, 1'b0, 4'h1};
    repeat (3) @(posedge clk);
    // Nine rounds of three flashes and seventeen rounds of one fit the window.
    flash_count(9 * (6 * FH + PS), 26, 28, 16, 18);
    $display("end of failure and compressor test");
    status_valid <= 1'b0;
    asc_start <= 1'b1;
    @(posedge clk);
    asc_start <= 1'b0;
    repeat (3) @(posedge clk);
    blink(30, 1, 4, 6);
    jumper <= 1'b1;
    repeat (3) @(posedge clk);
    blink(30, 2, 4, 6);
    $display("end of delay override test");
    @(posedge clk);
    rstn <= 1'b0;
    jumper <= 1'b0;
    stored_valid <= 1'b1;
    stored_code <= 10'h200;
    hold_on = 1'b1;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    step(40, 0);
    hold_on = 1'b0;
    repeat (12) @(posedge clk);
    step(20, 1);
    $display("end of stored code test");
    close_out();
  end
endmodule : diag_led_code_display_bench
`default_nettype wire
